// [t2c_params.svh]
// offsets, field positions, reset values and counts of the 8-bit timer 2
`ifndef T2C_PARAMS_SVH
`define T2C_PARAMS_SVH

// ----------------------------------------------------------------------------
// register select codes on the cpu port
// ----------------------------------------------------------------------------
`define T2C_SEL_COUNT      3'h0
`define T2C_SEL_CMP_A      3'h1
`define T2C_SEL_CMP_B      3'h2
`define T2C_SEL_CAPTURE    3'h3
`define T2C_SEL_CONTROL    3'h4
`define T2C_SEL_CLKSEL     3'h5
`define T2C_SEL_CLRMODE    3'h6
`define T2C_SEL_OUTCTL     3'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define T2C_CTRL_RST       8'h00
`define T2C_CLKSEL_RST     4'h0
`define T2C_CLRMODE_RST    8'h10
`define T2C_OUTCTL_RST     4'h0
`define T2C_COUNT_RST      8'h00

// ----------------------------------------------------------------------------
// timer_control fields
// ----------------------------------------------------------------------------
`define T2C_CTL_CE         7
`define T2C_CTL_OVF        6
`define T2C_CTL_ONESHOT    5
`define T2C_CTL_RSV        4

// ----------------------------------------------------------------------------
// clear_and_output_mode fields
// ----------------------------------------------------------------------------
`define T2C_CRC_CLR_B      0
`define T2C_CRC_CLR_CAP    1
`define T2C_CRC_MODE_LO    4

// ----------------------------------------------------------------------------
// output_level_enable upper nibble, stored as bits 3:0
// ----------------------------------------------------------------------------
`define T2C_OL_ALV_A       0
`define T2C_OL_EN_A        1
`define T2C_OL_ALV_B       2
`define T2C_OL_EN_B        3

// ----------------------------------------------------------------------------
// clock_select codes and counts
// ----------------------------------------------------------------------------
`define T2C_CKS_EXT        4'h8
`define T2C_CKS_LAST_INT   4'h5
`define T2C_CNT_MAX        8'hFF
`define T2C_EVT_MIN_BOTH   16
`define T2C_EVT_MIN_ONE    12

`endif

// [t2c_pkg.sv]
// types of the 8-bit timer 2
package t2c_pkg;

  typedef enum logic [1:0] {
    T2C_OM_RESERVED = 2'h0,
    T2C_OM_TOGGLE   = 2'h1,
    T2C_OM_PWM      = 2'h2,
    T2C_OM_PPG      = 2'h3
  } t2c_omode_e;

  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0] clk_sel;
    logic [7:0] clr_mode;
    logic [3:0] out_ctl;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] capture;
    logic [7:0] count;
    logic       load_zero;
    logic       tick_d;
    logic       restart;
    logic       irq_a;
    logic       irq_b;
    logic       irq_cap;
    logic       irq_evt;
    logic       st_a;
    logic       st_b;
    logic       pin_a;
    logic       pin_b;
    logic [7:0] rdata;
  } t2c_state_s;

endpackage

// [t2c_prescaler.sv]
// free-running prescaler giving one-cycle ticks at fclk/16 to fclk/512
`timescale 1ns/10ps
`include "t2c_params.svh"
module t2c_prescaler (
  // clock and reset
  input  logic       mclk,
  input  logic       sys_rst,
  // divider choice, 0 is /16 up to 5 is /512
  input  logic [3:0] sel,
  // one-cycle tick
  output logic       tick
);

  logic [8:0] div_reg;
  logic       tick_next;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 9'h000;
      tick    <= 1'b0;
    end else begin
      div_reg <= div_reg + 9'h001;
      tick    <= tick_next;
    end
  end

  // a tick when every bit below the chosen divisor is one
  always_comb begin
    unique case (sel)
      4'h0:    tick_next = &div_reg[3:0];
      4'h1:    tick_next = &div_reg[4:0];
      4'h2:    tick_next = &div_reg[5:0];
      4'h3:    tick_next = &div_reg[6:0];
      4'h4:    tick_next = &div_reg[7:0];
      4'h5:    tick_next = &div_reg[8:0];
      default: tick_next = 1'b0;
    endcase
  end

endmodule // t2c_prescaler

// [t2c_props.sv]
// concurrent checks on the port behaviour of the 8-bit timer 2
`timescale 1ns/10ps
`include "t2c_params.svh"
module t2c_props (
  // clock and reset
  input logic       mclk,
  input logic       sys_rst,
  // cpu register port
  input logic [2:0] cpu_sel,
  input logic       cpu_wr,
  input logic       cpu_rd,
  input logic [7:0] cpu_wdata,
  input logic [7:0] cpu_rdata,
  // pins and requests
  input logic [1:0] capture_edge_mode,
  input logic [1:0] event_edge_mode,
  input logic       capture_input,
  input logic       event_count_input,
  input logic       timer_out_a,
  input logic       timer_out_b,
  input logic       match_a_irq,
  input logic       match_b_irq,
  input logic       capture_irq,
  input logic       event_input_irq
);
  // ---------------------------------------------------------------------
  // shadow of the enable bit and output control seen on the cpu port
  // ---------------------------------------------------------------------
  logic       en_reg;
  logic [3:0] ol_reg;
  logic [1:0] ol_age_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg     <= 1'b0;
      ol_reg     <= 4'h0;
      ol_age_reg <= 2'h0;
    end else begin
      if (cpu_wr && cpu_sel == `T2C_SEL_CONTROL) en_reg <= cpu_wdata[7];
      if (cpu_wr && cpu_sel == `T2C_SEL_OUTCTL) begin
        ol_reg     <= cpu_wdata[7:4];
        ol_age_reg <= 2'h0;
      end else if (ol_age_reg != 2'h3) ol_age_reg <= ol_age_reg + 2'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_ctl_wr_rd;
    cpu_wr && cpu_sel == `T2C_SEL_CONTROL ##1
      cpu_rd && !cpu_wr && cpu_sel == `T2C_SEL_CONTROL;
  endsequence
  sequence s_evt_rise;
    $rose(event_count_input) && event_edge_mode == 2'h1;
  endsequence
  sequence s_cap_rise;
    $rose(capture_input) && capture_edge_mode == 2'h1 && en_reg;
  endsequence
  irq_a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a request longer than one cycle");
  irq_b_pulse_a: assert property (match_b_irq |=> !match_b_irq)
    else $error("match b request longer than one cycle");
  rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  ctrl_readback_a: assert property (s_ctl_wr_rd |=>
    cpu_rdata[7] == $past(cpu_wdata[7], 2) && !cpu_rdata[4] &&
    {cpu_rdata[5], cpu_rdata[3:0]} == $past({cpu_wdata[5], cpu_wdata[3:0]}, 2))
    else $error("control register read back wrong");
  wo_read_zero_a: assert property (cpu_rd && cpu_sel >= `T2C_SEL_CLKSEL
    |=> cpu_rdata == 8'h00) else $error("write-only register read not 00");
  event_irq_a: assert property (s_evt_rise |-> ##[3:7] event_input_irq)
    else $error("event edge gave no request");
  capture_irq_a: assert property (s_cap_rise |-> ##[3:8] capture_irq)
    else $error("capture edge gave no request");
  pin_a_level_a: assert property (ol_age_reg == 2'h3 && !ol_reg[1]
    |-> timer_out_a == ol_reg[0]) else $error("pin a not at fixed level");
  pin_b_level_a: assert property (ol_age_reg == 2'h3 && !ol_reg[3]
    |-> timer_out_b == ol_reg[2]) else $error("pin b not at fixed level");
  match_gate_a: assert property ((!en_reg) [*4]
    |-> !match_a_irq && !match_b_irq) else $error("match while stopped");
endmodule // t2c_props
bind t2c_top t2c_props u_props (.mclk(mclk), .sys_rst(sys_rst),
  .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .capture_edge_mode(capture_edge_mode), .event_edge_mode(event_edge_mode),
  .capture_input(capture_input), .event_count_input(event_count_input),
  .timer_out_a(timer_out_a), .timer_out_b(timer_out_b),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
  .capture_irq(capture_irq), .event_input_irq(event_input_irq));

// [t2c_pulse_src.sv]
// external pulse sources on the capture and event pins
`timescale 1ns/10ps
`include "t2c_params.svh"
module t2c_pulse_src (
  // clock
  input  logic mclk,
  // pins
  output logic capture_input,
  output logic event_count_input
);
  initial begin
    capture_input     = 1'b0;
    event_count_input = 1'b0;
  end
  // levels are held for the both-edge minimum so no edge is ever lost
  task automatic evt_pulses(input int n);
    repeat (n) begin
      repeat (`T2C_EVT_MIN_BOTH) @(posedge mclk);
      event_count_input <= 1'b1;
      repeat (`T2C_EVT_MIN_BOTH) @(posedge mclk);
      event_count_input <= 1'b0;
    end
  endtask
  task automatic cap_drive(input logic v);
    @(posedge mclk);
    capture_input <= v;
  endtask
endmodule // t2c_pulse_src

// [t2c_sync_edge.sv]
// two-stage synchroniser and selectable edge detector for one input pin
`timescale 1ns/10ps
module t2c_sync_edge (
  // clock and reset
  input  logic       mclk,
  input  logic       sys_rst,
  // pin and edge choice: 00 falling, 01 rising, 1x both
  input  logic       pin,
  input  logic [1:0] edge_mode,
  // one-cycle pulse on a valid edge
  output logic       edge_pulse
);

  logic [2:0] sync_reg;
  logic       edge_next;

  // ----------------------------------------------------------------------
  // stage 0 is read only by stage 1
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_reg   <= 3'h0;
      edge_pulse <= 1'b0;
    end else begin
      sync_reg   <= {sync_reg[1:0], pin};
      edge_pulse <= edge_next;
    end
  end

  always_comb begin
    unique case (edge_mode)
      2'h0:    edge_next = sync_reg[2] & ~sync_reg[1];
      2'h1:    edge_next = ~sync_reg[2] & sync_reg[1];
      default: edge_next = sync_reg[2] ^ sync_reg[1];
    endcase
  end

endmodule // t2c_sync_edge

// [t2c_top.sv]
// 8-bit timer 2: counter, two compares, capture and output control
`timescale 1ns/10ps
`include "t2c_params.svh"

// Function
// - reset clears the counter to 00H and leaves it stopped.
// - counter reads as 8 bits; writes to it are ignored.
// - counter equal to a compare raises its irq and a match signal.
// - both compares read and write; reset value is undefined.
// - valid capture edge copies the counter into the capture register.
// - capture value holds until next capture or a read.
// - capture edge gives irq and trigger; event edge gives tick and irq.
// - disabled pin drives its level bit; enabled pin drives pulses.
// - timer_control upper nibble, enable at bit 7, read/write, resets 00H; bits 3:0 are also kept and read back here.
// - one-shot bit picks mode; enable 0 clears and stops, 1 counts.
// - normal wrap from FFH sets overflow flag; only software clears it.
// - clock_select upper nibble picks fclk divider or event input.
// - clear_and_output_mode sets auto-clears and pin modes, resets 10H.
// - output_level_enable upper nibble holds levels and enables, resets 0.
// - after enabling, first tick loads zero, later ticks increment.
// - after disabling, next tick clears; capture and matches stop.
// - rewriting enable as 1 while 1 disturbs nothing.
// - auto-clear keeps the count and loads zero on the next tick.
// - re-enable before pending clear: that tick clears and starts.
// - event counting is just choosing the event input as clock.
// - prescaler divides the system clock; a selector picks one.
// - overflow flag at bit 6, one-shot select at bit 5.
// - one-shot stops at FFH with flag set; clearing flag restarts.
module t2c_top (
  // clock and reset
  input  logic       mclk,
  input  logic       sys_rst,
  // cpu register port, 8-bit accesses
  input  logic [2:0] cpu_sel,
  input  logic       cpu_wr,
  input  logic       cpu_rd,
  input  logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // edge choice held in the external edge_polarity_register
  input  logic [1:0] capture_edge_mode,
  input  logic [1:0] event_edge_mode,
  // external pins
  input  logic       capture_input,
  input  logic       event_count_input,
  output logic       timer_out_a,
  output logic       timer_out_b,
  // interrupt requests, one-cycle pulses
  output logic       match_a_irq,
  output logic       match_b_irq,
  output logic       capture_irq,
  output logic       event_input_irq
);

  t2c_pkg::t2c_state_s st_reg;
  t2c_pkg::t2c_state_s st_next;
  t2c_pkg::t2c_omode_e out_mode;

  logic cap_edge;
  logic evt_edge;
  logic presc_tick;
  logic tick;
  logic ce;
  logic one_shot;
  logic halt;
  logic ovf_set;
  logic hit_a;
  logic hit_b;

  // --------------------------------------------------------------------------
  // input synchronisers and edge detection
  // --------------------------------------------------------------------------
  t2c_sync_edge u_cap_edge (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .pin        (capture_input),
    .edge_mode  (capture_edge_mode),
    .edge_pulse (cap_edge)
  );

  t2c_sync_edge u_evt_edge (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .pin        (event_count_input),
    .edge_mode  (event_edge_mode),
    .edge_pulse (evt_edge)
  );

  // --------------------------------------------------------------------------
  // prescaler and count clock selector
  // --------------------------------------------------------------------------
  t2c_prescaler u_presc (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .sel     (st_reg.clk_sel),
    .tick    (presc_tick)
  );

  // event counting needs no mode of its own, only this selector code
  assign tick = (st_reg.clk_sel == `T2C_CKS_EXT) ? evt_edge :
                presc_tick;

  assign ce       = st_reg.ctl[`T2C_CTL_CE];
  assign one_shot = st_reg.ctl[`T2C_CTL_ONESHOT];
  assign halt     = one_shot & st_reg.ctl[`T2C_CTL_OVF];
  assign out_mode = t2c_pkg::t2c_omode_e'(
                      st_reg.clr_mode[`T2C_CRC_MODE_LO +: 2]);

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    ovf_set         = 1'b0;
    hit_a           = 1'b0;
    hit_b           = 1'b0;
    st_next.tick_d  = tick;
    st_next.restart = 1'b0;
    st_next.irq_a   = 1'b0;
    st_next.irq_b   = 1'b0;
    st_next.irq_cap = cap_edge;
    st_next.irq_evt = evt_edge;

    // ---------------- counter on each count clock ----------------
    // a pending zero load wins over counting; with enable low it also stops
    if (tick) begin
      if (st_reg.load_zero) begin
        st_next.count     = `T2C_COUNT_RST;
        st_next.load_zero = 1'b0;
        st_next.restart   = 1'b1;
      end else if (ce && !halt) begin
        if (st_reg.count == `T2C_CNT_MAX) begin
          st_next.count   = `T2C_COUNT_RST;
          st_next.restart = 1'b1;
          ovf_set         = 1'b1;
        end else begin
          st_next.count = st_reg.count + 8'h01;
          // one-shot parks at full count with the flag raised
          if (one_shot && st_reg.count == (`T2C_CNT_MAX - 8'h01)) begin
            ovf_set = 1'b1;
          end
        end
      end
    end

    // ---------------- compare, one cycle after the count moved ----------------
    // matching is judged only after a count clock, so a held value
    // raises its request once rather than on every system clock
    if (st_reg.tick_d && ce) begin
      hit_a = (st_reg.count == st_reg.cmp_a);
      hit_b = (st_reg.count == st_reg.cmp_b);
    end
    st_next.irq_a = hit_a;
    st_next.irq_b = hit_b;
    if (hit_b && st_reg.clr_mode[`T2C_CRC_CLR_B]) begin
      st_next.load_zero = 1'b1;
    end

    // ---------------- capture ----------------
    if (cap_edge && ce) begin
      st_next.capture = st_reg.count;
      if (st_reg.clr_mode[`T2C_CRC_CLR_CAP]) begin
        st_next.load_zero = 1'b1;
      end
    end

    // ---------------- output control stage ----------------
    unique case (out_mode)
      t2c_pkg::T2C_OM_RESERVED,
      t2c_pkg::T2C_OM_TOGGLE: begin
        if (st_reg.irq_a) begin
          st_next.st_a = ~st_reg.st_a;
        end
        if (st_reg.irq_b) begin
          st_next.st_b = ~st_reg.st_b;
        end
      end
      t2c_pkg::T2C_OM_PWM: begin
        // active from the restart at zero until the matching compare
        if (st_reg.irq_a) begin
          st_next.st_a = 1'b0;
        end else if (st_reg.restart) begin
          st_next.st_a = 1'b1;
        end
        if (st_reg.irq_b) begin
          st_next.st_b = 1'b0;
        end else if (st_reg.restart) begin
          st_next.st_b = 1'b1;
        end
      end
      t2c_pkg::T2C_OM_PPG: begin
        // pin a is a pulse from compare a to compare b
        if (st_reg.irq_b) begin
          st_next.st_a = 1'b0;
        end else if (st_reg.irq_a) begin
          st_next.st_a = 1'b1;
        end
        if (st_reg.irq_b) begin
          st_next.st_b = ~st_reg.st_b;
        end
      end
    endcase

    // a disabled pin sits at its level bit; an enabled one shows pulses
    st_next.pin_a = st_reg.out_ctl[`T2C_OL_EN_A] ?
      (st_reg.out_ctl[`T2C_OL_ALV_A] ? st_reg.st_a : ~st_reg.st_a) :
      st_reg.out_ctl[`T2C_OL_ALV_A];
    st_next.pin_b = st_reg.out_ctl[`T2C_OL_EN_B] ?
      (st_reg.out_ctl[`T2C_OL_ALV_B] ? st_reg.st_b : ~st_reg.st_b) :
      st_reg.out_ctl[`T2C_OL_ALV_B];

    // ---------------- cpu writes ----------------
    if (cpu_wr) begin
      unique case (cpu_sel)
        `T2C_SEL_CMP_A: st_next.cmp_a = cpu_wdata;
        `T2C_SEL_CMP_B: st_next.cmp_b = cpu_wdata;
        `T2C_SEL_CONTROL: begin
          // enable edge either way schedules a zero load; a repeated
          // write of enable=1 leaves the count alone
          if (ce != cpu_wdata[`T2C_CTL_CE]) begin
            st_next.load_zero = 1'b1;
          end
          // clearing the flag of a parked one-shot restarts it
          if (halt && !cpu_wdata[`T2C_CTL_OVF]) begin
            st_next.load_zero = 1'b1;
          end
          st_next.ctl[`T2C_CTL_CE]      = cpu_wdata[`T2C_CTL_CE];
          st_next.ctl[`T2C_CTL_ONESHOT] = cpu_wdata[`T2C_CTL_ONESHOT];
          // software may only clear the flag, never set it
          st_next.ctl[`T2C_CTL_OVF] = st_reg.ctl[`T2C_CTL_OVF] &
                                      cpu_wdata[`T2C_CTL_OVF];
          st_next.ctl[`T2C_CTL_RSV] = 1'b0;
          st_next.ctl[3:0]          = cpu_wdata[3:0];
        end
        `T2C_SEL_CLKSEL:  st_next.clk_sel  = cpu_wdata[7:4];
        `T2C_SEL_CLRMODE: st_next.clr_mode = cpu_wdata;
        `T2C_SEL_OUTCTL:  st_next.out_ctl  = cpu_wdata[7:4];
        // the counter and capture register ignore writes
        default: st_next.count = st_next.count;
      endcase
    end

    // hardware setting the flag wins over a clear in the same cycle
    if (ovf_set) begin
      st_next.ctl[`T2C_CTL_OVF] = 1'b1;
    end

    // ---------------- cpu reads, answer one cycle later ----------------
    if (cpu_rd) begin
      unique case (cpu_sel)
        `T2C_SEL_COUNT:   st_next.rdata = st_reg.count;
        `T2C_SEL_CMP_A:   st_next.rdata = st_reg.cmp_a;
        `T2C_SEL_CMP_B:   st_next.rdata = st_reg.cmp_b;
        // after a read the value may be anything; it simply stays
        `T2C_SEL_CAPTURE: st_next.rdata = st_reg.capture;
        `T2C_SEL_CONTROL: st_next.rdata = st_reg.ctl;
        // write-only registers read as zero
        default:          st_next.rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // compares and capture have no guaranteed reset value; they are
  // cleared only so that simulation starts from known bits
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.ctl       <= `T2C_CTRL_RST;
      st_reg.clk_sel   <= `T2C_CLKSEL_RST;
      st_reg.clr_mode  <= `T2C_CLRMODE_RST;
      st_reg.out_ctl   <= `T2C_OUTCTL_RST;
      st_reg.cmp_a     <= 8'h00;
      st_reg.cmp_b     <= 8'h00;
      st_reg.capture   <= 8'h00;
      st_reg.count     <= `T2C_COUNT_RST;
      st_reg.load_zero <= 1'b0;
      st_reg.tick_d    <= 1'b0;
      st_reg.restart   <= 1'b0;
      st_reg.irq_a     <= 1'b0;
      st_reg.irq_b     <= 1'b0;
      st_reg.irq_cap   <= 1'b0;
      st_reg.irq_evt   <= 1'b0;
      st_reg.st_a      <= 1'b0;
      st_reg.st_b      <= 1'b0;
      st_reg.pin_a     <= 1'b0;
      st_reg.pin_b     <= 1'b0;
      st_reg.rdata     <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, each straight from the state register
  // --------------------------------------------------------------------------
  assign cpu_rdata       = st_reg.rdata;
  assign timer_out_a     = st_reg.pin_a;
  assign timer_out_b     = st_reg.pin_b;
  assign match_a_irq     = st_reg.irq_a;
  assign match_b_irq     = st_reg.irq_b;
  assign capture_irq     = st_reg.irq_cap;
  assign event_input_irq = st_reg.irq_evt;

endmodule // t2c_top

// [t2c_top_tb.sv]
// register-level testbench of the 8-bit timer 2
`timescale 1ns/10ps
`include "t2c_params.svh"
module t2c_top_tb;
  logic       mclk, sys_rst, cpu_wr, cpu_rd;
  logic [2:0] cpu_sel;
  logic [7:0] cpu_wdata, cpu_rdata, rv;
  logic [1:0] capture_edge_mode, event_edge_mode;
  logic       capture_input, event_count_input, timer_out_a, timer_out_b;
  logic       match_a_irq, match_b_irq, capture_irq, event_input_irq, pin_q;
  int         n_errors, n_checks, n_evt, waited, k;
  t2c_top dut (.mclk(mclk), .sys_rst(sys_rst), .cpu_sel(cpu_sel),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .capture_edge_mode(capture_edge_mode),
    .event_edge_mode(event_edge_mode), .capture_input(capture_input),
    .event_count_input(event_count_input), .timer_out_a(timer_out_a),
    .timer_out_b(timer_out_b), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .capture_irq(capture_irq),
    .event_input_irq(event_input_irq));
  t2c_pulse_src src (.mclk(mclk), .capture_input(capture_input),
    .event_count_input(event_count_input));
  // ---------------------------------------------------------------------
  // clock, event tally and bus tasks
  // ---------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (event_input_irq === 1'b1) n_evt++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge mclk);
    cpu_wr    <= 1'b1;
    cpu_sel   <= sel;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_wr <= 1'b0;
  endtask
  // entered just after an edge, so a read may follow a write back to back
  task automatic rck(input logic [2:0] sel, input logic [7:0] exp);
    cpu_rd  <= 1'b1;
    cpu_sel <= sel;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1 rv = cpu_rdata;
    check({8'h00, rv}, {8'h00, exp});
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for 0 match a, 1 match b, 2 capture request
  task automatic wait_irq(input int w, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk);
      #1;
      waited = i + 1;
      if ((w == 0 && match_a_irq === 1'b1) || (w == 1 && match_b_irq === 1'b1)
          || (w == 2 && capture_irq === 1'b1)) return;
    end
    n_errors++;
    $display("Error at %0t: wait for request ran out", $time);
    stop_test();
  endtask
  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {sys_rst, cpu_wr, cpu_rd, cpu_sel, cpu_wdata} = {1'b1, 13'h0000};
    {capture_edge_mode, event_edge_mode} = 4'h5;
    n_errors = 0;
    n_checks = 0;
    n_evt    = 0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rck(`T2C_SEL_COUNT, 8'h00);
    rck(`T2C_SEL_CONTROL, 8'h00);
    for (k = 5; k < 8; k++) rck(3'(k), 8'h00);
    wr(`T2C_SEL_COUNT, 8'hFF);
    rck(`T2C_SEL_COUNT, 8'h00);
    wr(`T2C_SEL_CMP_A, 8'h05);
    wr(`T2C_SEL_CMP_B, 8'h0A);
    rck(`T2C_SEL_CMP_A, 8'h05);
    rck(`T2C_SEL_CMP_B, 8'h0A);
    wr(`T2C_SEL_CONTROL, 8'h2F);
    rck(`T2C_SEL_CONTROL, 8'h2F);
    wr(`T2C_SEL_CONTROL, 8'h00);
    done("registers");
    wr(`T2C_SEL_OUTCTL, 8'h10);
    repeat (3) @(posedge mclk);
    check({timer_out_a, timer_out_b}, 16'h0002);
    wr(`T2C_SEL_OUTCTL, 8'h40);
    repeat (3) @(posedge mclk);
    check({timer_out_a, timer_out_b}, 16'h0001);
    wr(`T2C_SEL_OUTCTL, 8'h00);
    done("fixed pins");
    wr(`T2C_SEL_CLRMODE, 8'h11);
    wr(`T2C_SEL_CONTROL, 8'h80);
    wait_irq(0, 200);
    rck(`T2C_SEL_COUNT, 8'h05);
    wr(`T2C_SEL_CONTROL, 8'h80);
    repeat (16) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'h06);
    wait_irq(1, 200);
    rck(`T2C_SEL_COUNT, 8'h0A);
    repeat (16) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'h00);
    done("compare and clear");
    wr(`T2C_SEL_CMP_B, 8'h01);
    for (k = 0; k < 6; k++) begin
      wr(`T2C_SEL_CLKSEL, 8'(k << 4));
      wait_irq(1, 2100);
      wait_irq(1, 2100);
      check(16'(waited), 16'(32 << k));
    end
    done("clock select");
    wr(`T2C_SEL_CLKSEL, 8'h00);
    wr(`T2C_SEL_CLRMODE, 8'h10);
    wr(`T2C_SEL_CONTROL, 8'h00);
    wr(`T2C_SEL_CONTROL, 8'h80);
    repeat (4200) @(posedge mclk);
    rck(`T2C_SEL_CONTROL, 8'hC0);
    wr(`T2C_SEL_CONTROL, 8'h80);
    rck(`T2C_SEL_CONTROL, 8'h80);
    wr(`T2C_SEL_CONTROL, 8'hA0);
    repeat (4200) @(posedge mclk);
    rck(`T2C_SEL_CONTROL, 8'hE0);
    repeat (40) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'hFF);
    wr(`T2C_SEL_CONTROL, 8'hA0);
    wait_irq(0, 200);
    rck(`T2C_SEL_COUNT, 8'h05);
    wr(`T2C_SEL_CONTROL, 8'h00);
    repeat (20) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'h00);
    done("overflow and one-shot");
    wr(`T2C_SEL_CLKSEL, {`T2C_CKS_EXT, 4'h0});
    wr(`T2C_SEL_CMP_A, 8'h02);
    wr(`T2C_SEL_OUTCTL, 8'h20);
    wr(`T2C_SEL_CONTROL, 8'h80);
    pin_q = timer_out_a;
    src.evt_pulses(5);
    repeat (10) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'h04);
    check(16'(n_evt), 16'd5);
    check({15'h0000, timer_out_a}, {15'h0000, ~pin_q});
    done("event counting");
    wr(`T2C_SEL_CLRMODE, 8'h12);
    src.cap_drive(1'b1);
    wait_irq(2, 20);
    rck(`T2C_SEL_CAPTURE, 8'h04);
    rck(`T2C_SEL_CAPTURE, 8'h04);
    src.cap_drive(1'b0);
    src.evt_pulses(1);
    repeat (10) @(posedge mclk);
    rck(`T2C_SEL_COUNT, 8'h00);
    done("capture");
    stop_test();
  end
endmodule // t2c_top_tb
